// ===== pkg/state_timer_consts.vh
// register offsets, field positions and reset values of the state timer
`ifndef STATE_TIMER_CONSTS_VH
`define STATE_TIMER_CONSTS_VH
`define ST_A_CFG 8'h00
`define ST_A_CTRL 8'h04
`define ST_A_COUNT 8'h08
`define ST_A_STATE 8'h0C
`define ST_A_INSEL 8'h10
`define ST_A_OUT 8'h14
`define ST_A_FLAG 8'h18
`define ST_A_MODE 8'h1C
`define ST_B_MATCH 3'h1
`define ST_B_CAPC 3'h2
`define ST_B_EVST 3'h3
`define ST_B_EVC 3'h4
`define ST_B_EVA 3'h5
`define CFG_UNIFY 0
`define CFG_INCLK 1
`define CFG_CKSEL_LO 2
`define CFG_BIDIR_L 4
`define CFG_BIDIR_H 5
`define CFG_ALIM_L 6
`define CFG_ALIM_H 7
`define CTRL_STOP_L 0
`define CTRL_HALT_L 1
`define CTRL_STOP_H 2
`define CTRL_HALT_H 3
`define CTRL_RST 4'hA
`define EVC_MSEL_LO 0
`define EVC_HALF 3
`define EVC_IOSEL_LO 4
`define EVC_IOCND_LO 8
`define EVC_COMB_LO 10
`define EVC_HOLD 12
`define EVC_DIR_LO 13
`define EVC_STLD 15
`define EVC_NXT_LO 16
`define EVA_LIMIT 6
`define EVA_STOP 7
`define EVA_START 8
`define EVA_HALT 9
`define EVA_DMA_LO 10
`define COND_LOW 2'h0
`define COND_RISE 2'h1
`define COND_FALL 2'h2
`define COND_HIGH 2'h3
`define COMB_OR 2'h0
`define COMB_MATCH 2'h1
`define COMB_IO 2'h2
`define DIR_UP 2'h1
`define DIR_DOWN 2'h2
`define MODE_ADC_LO 8
`endif

// ===== tb/src_model.sv
// source model: pins, adc compare, comparator and core signals as pulses
`timescale 1ns/1ps
module src_model (
  input wire i_clk,
  input wire i_go,
  input wire [2:0] i_sel,
  input wire i_slow,
  output reg [7:0] o_src
);
  reg [1:0] hold_q; // extra cycles a slow pulse stays high
  initial begin
    o_src = 8'h00;
    hold_q = 2'h0;
  end
  // one source high at a time, changes only on clock edges so never above 25 MHz
  always @(posedge i_clk) begin
    if (i_go) begin
      o_src <= 8'h01 << i_sel;
      hold_q <= i_slow ? 2'h3 : 2'h0;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      o_src <= 8'h00;
    end
  end
endmodule

// ===== tb/state_timer_chk.sv
// concurrent checks on the state timer ports
`timescale 1ns/1ps
module state_timer_chk (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [31:0] o_readdata,
  input wire o_waitrequest,
  input wire [3:0] i_pin,
  input wire i_adc_thcmp,
  input wire i_cmp_out,
  input wire i_core_event_out,
  input wire i_core_debug_halt_flag,
  input wire [5:0] o_out,
  input wire o_adc_trig,
  input wire [1:0] o_dma_req,
  input wire [7:0] o_event_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // any bus request in flight
  wire req = i_read | i_write;
  a_wait_first: assert property ($rose(req) |-> o_waitrequest) else $error("no wait cycle");
  a_wait_bound: assert property ($rose(req) |=> !o_waitrequest) else $error("answer late");
  a_wait_idle: assert property (!req |-> !o_waitrequest) else $error("wait without request");
  a_rdata_hold: assert property ($changed(o_readdata) |-> $past(i_read & o_waitrequest))
    else $error("read data moved");
  a_dma_event: assert property (o_dma_req != 2'h0 |-> o_event_req != 8'h00) else $error("dma alone");
  a_trig_out: assert property (o_adc_trig |-> o_out != 6'h00) else $error("trigger not an output");
  a_out_cause: assert property ($changed(o_out) && !$past(i_write & ~o_waitrequest) |-> ##[0:1] o_event_req != 8'h00)
    else $error("output moved without event");
  a_reset_clear: assert property ($rose(i_nrst) |-> o_out == 6'h00 && o_dma_req == 2'h0 && o_event_req == 8'h00)
    else $error("outputs not cleared");
  // main scenarios reached
  cover property (o_event_req[0]);
  cover property (o_dma_req[1]);
  cover property ($rose(o_adc_trig));
endmodule

// ===== tb/tb.sv
// self-checking bench for the state timer
`timescale 1ns/1ps
`include "state_timer_consts.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic i_clk = 1'b0; // system clock
  logic i_nrst = 1'b0; // async reset, low active
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h00000000;
  logic go = 1'b0; // partner pulse request
  logic [2:0] sel = 3'h0; // partner source index
  logic slow = 1'b0; // partner long pulse
  wire [7:0] src;
  wire [31:0] o_readdata;
  wire o_waitrequest;
  wire [5:0] o_out;
  wire o_adc_trig;
  wire [1:0] o_dma_req;
  wire [7:0] o_event_req;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int ev0_n = 0; // pulses of event 0
  int n;
  logic [31:0] rd;
  logic [31:0] c0;
  // write, read back, expected
  logic [71:0] rows [0:6] = '{{`ST_A_STATE, 32'hFFFFFFFF, 32'h00000007}, {`ST_A_INSEL, 32'hFFFFFFFF, 32'h00000FFF},
    {`ST_A_MODE, 32'hFFFFFFFF, 32'h000007FF}, {8'h20, 32'h12345678, 32'h12345678}, {8'hFC, 32'hFFFFFFFF, 32'h0},
    {`ST_A_MODE, 32'h00000500, 32'h00000500}, {`ST_A_OUT, 32'hFFFFFFFF, 32'h0000003F}};
  // setup: event0 match0 in state 0 to state 1, event1 input rise in state 1, event2 match0 always
  logic [39:0] cfg [0:13] = '{{`ST_A_OUT, 32'h0}, {`ST_A_STATE, 32'h0}, {8'h20, 32'h4}, {8'h60, 32'h1},
    {8'h80, 32'h00018400}, {8'hA0, 32'h00000401}, {8'h68, 32'hFF}, {8'h88, 32'h00000400}, {8'hA8, 32'h4},
    {8'h64, 32'h2}, {8'h84, 32'h00000900}, {8'hA4, 32'h00000802}, {`ST_A_CFG, 32'h41}, {`ST_A_CTRL, 32'h0}};
  always #20 i_clk = ~i_clk;
  state_timer dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_pin(src[3:0]),
    .i_adc_thcmp(src[4]), .i_cmp_out(src[5]), .i_core_event_out(src[6]), .i_core_debug_halt_flag(src[7]),
    .o_out(o_out), .o_adc_trig(o_adc_trig), .o_dma_req(o_dma_req), .o_event_req(o_event_req));
  src_model far (.i_clk(i_clk), .i_go(go), .i_sel(sel), .i_slow(slow), .o_src(src));
  // verdict and end of run
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one bus transfer, entered at a rising edge; held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      k = 0;
      i_address <= a;
      i_write <= wr;
      i_read <= ~wr;
      i_writedata <= d;
      @(posedge i_clk);
      while (o_waitrequest !== 1'b0 && k < 50) begin
        k++;
        @(posedge i_clk);
      end
      if (k == 50) bad_count++;
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  // count cycles until an event request pulse, up to lim; ends on a falling edge
  task wait_evt(input int b, input int lim);
    begin
      n = 0;
      @(negedge i_clk);
      while (o_event_req[b] !== 1'b1 && n < lim) begin
        n++;
        @(negedge i_clk);
      end
    end
  endtask
  // ask the partner for one source pulse
  task pulse(input logic [2:0] s, input logic sl);
    begin
      sel <= s;
      slow <= sl;
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
    end
  endtask
  // watchdog on the whole run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      test_done;
    end
  end
  always @(negedge i_clk) begin
    if (o_event_req[0] === 1'b1) ev0_n++;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    bus(1'b0, `ST_A_CTRL, 32'h0);
    `CHK(rd, {28'h0, `CTRL_RST})
    bus(1'b0, `ST_A_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, rows[i][71:64], rows[i][63:32]);
      bus(1'b0, rows[i][71:64], 32'h0);
      `CHK(rd, rows[i][31:0])
    end
    `CHK(o_out, 6'h3F)
    `CHK(o_adc_trig, 1'b1)
    for (int i = 0; i < 14; i++) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
    `CHK(o_adc_trig, 1'b0)
    wait_evt(0, 40);
    `CHK(n < 40, 1'b1)
    `CHK(o_dma_req, 2'h1)
    `CHK(o_out, 6'h05)
    @(posedge i_clk);
    wait_evt(2, 40);
    `CHK(n, 4)
    `CHK(o_out, 6'h01)
    `CHK(o_dma_req, 2'h0)
    repeat (20) @(posedge i_clk);
    bus(1'b0, `ST_A_STATE, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(ev0_n, 1)
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, `ST_A_INSEL, 32'(s));
      pulse(3'(s + 1), s[0]);
      wait_evt(1, 12);
      `CHK(n, 12)
      @(posedge i_clk);
      pulse(3'(s), s[0]);
      wait_evt(1, 12);
      `CHK(n >= 2 && n < 12, 1'b1)
      `CHK(o_dma_req, 2'h2)
      @(posedge i_clk);
    end
    bus(1'b0, `ST_A_FLAG, 32'h0);
    `CHK(rd, 32'h7)
    bus(1'b1, `ST_A_FLAG, 32'h3);
    bus(1'b0, `ST_A_FLAG, 32'h0);
    `CHK(rd, 32'h4)
    bus(1'b1, `ST_A_MODE, 32'h502);
    bus(1'b1, 8'h44, 32'h4);
    repeat (10) @(posedge i_clk);
    bus(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h4)
    bus(1'b1, `ST_A_CTRL, 32'h0000000A);
    bus(1'b0, `ST_A_COUNT, 32'h0);
    c0 = rd;
    bus(1'b0, `ST_A_COUNT, 32'h0);
    `CHK(rd, c0)
    bus(1'b1, `ST_A_CFG, 32'h0);
    bus(1'b1, `ST_A_COUNT, 32'h0000FFFF);
    bus(1'b1, `ST_A_CTRL, 32'h8);
    bus(1'b1, `ST_A_CTRL, 32'hA);
    bus(1'b0, `ST_A_COUNT, 32'h0);
    `CHK(rd, 32'h00000002)
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    bus(1'b0, `ST_A_STATE, 32'h0);
    `CHK(rd, 32'h0)
    test_done;
  end
endmodule
bind state_timer state_timer_chk chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_pin(i_pin), .i_adc_thcmp(i_adc_thcmp), .i_cmp_out(i_cmp_out), .i_core_event_out(i_core_event_out),
  .i_core_debug_halt_flag(i_core_debug_halt_flag), .o_out(o_out), .o_adc_trig(o_adc_trig),
  .o_dma_req(o_dma_req), .o_event_req(o_event_req));

// ===== verilog/state_timer.v
// state timer: counters, match/capture, events, states, outputs, bus slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - one 32-bit or two 16-bit counters
// - eight states, changed only by events or bus writes
// - eight registers, each match or capture
// - four inputs, each with own source selector
// - same eight sources on every selector
// - six outputs routed to pins
// - counter clock: system clock or input
// - count up only or up-down
// - match events limit, stop, halt, toggle
// - capture loads counter on event trigger
// - six PWM outputs sharing one period
// - event is match, io condition or both
// - events limit, halt, start, stop counter
// - events change state, toggle, request dma
// - match 0 acts as automatic limit
// - events qualified by count direction
// - match held pending until event fires
// - event acts only in masked states, running; a start event also while stopped
// - state kept across counter wraps
// - one output selectable as adc trigger
`include "state_timer_consts.vh"
module state_timer (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  output reg [31:0] o_readdata,
  output wire o_waitrequest,
  input wire [3:0] i_pin,
  input wire i_adc_thcmp,
  input wire i_cmp_out,
  input wire i_core_event_out,
  input wire i_core_debug_halt_flag,
  output wire [5:0] o_out,
  output wire o_adc_trig,
  output reg [1:0] o_dma_req,
  output reg [7:0] o_event_req
);
  // bus access to one of the eight-entry register arrays
  function hit8;
    input [7:0] a;
    input [2:0] b;
    begin
      hit8 = (a[7:5] == b);
    end
  endfunction
  // one count step: returns {down, value}
  function [32:0] step;
    input [31:0] v;
    input dn;
    input lim;
    input bi;
    input zero;
    begin
      if (!dn) begin
        if (lim && bi)
          step = {1'b1, v - 32'h1};
        else if (lim)
          step = {1'b0, 32'h0};
        else
          step = {1'b0, v + 32'h1};
      end else if (zero) begin
        step = {1'b0, v + 32'h1};
      end else begin
        step = {1'b1, v - 32'h1};
      end
    end
  endfunction
  // registers
  reg [7:0] cfg_q; // counter configuration
  reg [3:0] ctrl_q; // stop and halt per half
  reg [1:0] dir_q; // 1 while counting down, per half
  reg [31:0] cnt_q; // counter, low half and high half
  reg [2:0] state_q; // state variable
  reg [11:0] insel_q; // source choice per input
  reg [5:0] out_q; // output levels
  reg [7:0] flag_q; // sticky event flags
  reg [10:0] mode_q; // capture mode bits and adc output choice
  reg [31:0] mc_q [0:7]; // match or capture values
  reg [7:0] capc_q [0:7]; // events that capture into each register
  reg [7:0] evst_q [0:7]; // state mask per event
  reg [18:0] evc_q [0:7]; // condition per event
  reg [11:0] eva_q [0:7]; // actions per event
  reg [7:0] pend_q; // held match per event
  reg ack_q; // bus answer stage
  reg [7:0] s1_q; // first synchroniser stage
  reg [7:0] s2_q; // second synchroniser stage
  reg [9:0] iop_q; // io levels of the previous cycle
  reg [3:0] ckp_q; // previous input levels for clock edge
  // source synchroniser, one line per source
  // both stages run on the system clock; only the second stage feeds logic
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      s1_q <= {i_core_debug_halt_flag, i_core_event_out, i_cmp_out, i_adc_thcmp, i_pin};
      s2_q <= s1_q;
    end
  end
  // source selectors, identical on all four inputs
  wire [3:0] in_s;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_in
      assign in_s[g] = s2_q[insel_q[3*g+2:3*g]];
    end
  endgenerate
  // io levels seen by the events: outputs 0-5 above inputs 0-3
  wire [9:0] iov = {out_q, in_s};
  // one 32-bit counter when set, two 16-bit halves when clear
  wire unify = cfg_q[`CFG_UNIFY];
  // input that clocks the counter in input-clock mode
  wire [1:0] csel = cfg_q[`CFG_CKSEL_LO+1:`CFG_CKSEL_LO];
  // word index inside one of the eight-entry register arrays
  wire [2:0] asel = i_address[4:2];
  // count enable: every clock, or a rising edge of the chosen input
  wire tick = cfg_q[`CFG_INCLK] ? (in_s[csel] & ~ckp_q[csel]) : 1'b1;
  // a half runs while it is neither stopped nor halted
  wire [1:0] run = {~ctrl_q[`CTRL_STOP_H] & ~ctrl_q[`CTRL_HALT_H],
                    ~ctrl_q[`CTRL_STOP_L] & ~ctrl_q[`CTRL_HALT_L]};
  // match compare per register, full width and per half
  wire [7:0] m_u;
  wire [7:0] m_l;
  wire [7:0] m_h;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_m
      assign m_u[g] = ~mode_q[g] & (cnt_q == mc_q[g]);
      assign m_l[g] = ~mode_q[g] & (cnt_q[15:0] == mc_q[g][15:0]);
      assign m_h[g] = ~mode_q[g] & (cnt_q[31:16] == mc_q[g][31:16]);
    end
  endgenerate
  // event evaluation
  // fire: event taken this cycle; fh: the half that it acts on
  wire [7:0] fire;
  wire [7:0] fh;
  wire [7:0] mraw;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ev
      wire [18:0] c = evc_q[g];
      wire h = c[`EVC_HALF] & ~unify;
      wire [2:0] ms = c[`EVC_MSEL_LO+2:`EVC_MSEL_LO];
      wire [3:0] is = c[`EVC_IOSEL_LO+3:`EVC_IOSEL_LO];
      // io indices above the ten real lines read as a steady low
      wire lv = (is < 4'hA) ? iov[is] : 1'b0;
      wire pv = (is < 4'hA) ? iop_q[is] : 1'b0;
      reg io;
      reg cb;
      wire mt = mraw[g] | pend_q[g];
      wire dok = (c[`EVC_DIR_LO+1:`EVC_DIR_LO] == `DIR_UP) ? ~dir_q[h] :
                 (c[`EVC_DIR_LO+1:`EVC_DIR_LO] == `DIR_DOWN) ? dir_q[h] : 1'b1;
      wire hlt = h ? ctrl_q[`CTRL_HALT_H] : ctrl_q[`CTRL_HALT_L];
      // a start event may fire while stopped, never while halted
      wire act = run[h] | (~hlt & eva_q[g][`EVA_START]);
      assign fh[g] = h;
      assign mraw[g] = unify ? m_u[ms] : (h ? m_h[ms] : m_l[ms]);
      // io condition and combination with the match
      always @* begin
        case (c[`EVC_IOCND_LO+1:`EVC_IOCND_LO])
          `COND_LOW: io = ~lv;
          `COND_RISE: io = lv & ~pv;
          `COND_FALL: io = ~lv & pv;
          default: io = lv;
        endcase
        case (c[`EVC_COMB_LO+1:`EVC_COMB_LO])
          `COMB_OR: cb = mt | io;
          `COMB_MATCH: cb = mt;
          `COMB_IO: cb = io;
          default: cb = mt & io;
        endcase
      end
      assign fire[g] = tick & evst_q[g][state_q] & act & dok & cb;
    end
  endgenerate
  // per-event action collection
  reg [1:0] lim;
  reg [1:0] stp;
  reg [1:0] stt;
  reg [1:0] hlt_e;
  reg [5:0] tog;
  reg [1:0] dma;
  reg ld;
  reg [2:0] nxt;
  integer e;
  always @* begin
    lim = 2'b00;
    stp = 2'b00;
    stt = 2'b00;
    hlt_e = 2'b00;
    tog = 6'h00;
    dma = 2'b00;
    ld = 1'b0;
    nxt = state_q;
    for (e = 0; e < 8; e = e + 1) begin
      if (fire[e]) begin
        lim[fh[e]] = lim[fh[e]] | eva_q[e][`EVA_LIMIT];
        stp[fh[e]] = stp[fh[e]] | eva_q[e][`EVA_STOP];
        stt[fh[e]] = stt[fh[e]] | eva_q[e][`EVA_START];
        hlt_e[fh[e]] = hlt_e[fh[e]] | eva_q[e][`EVA_HALT];
        tog = tog ^ eva_q[e][5:0];
        dma = dma | eva_q[e][`EVA_DMA_LO+1:`EVA_DMA_LO];
        // with several state loads at once the highest event index wins
        if (evc_q[e][`EVC_STLD]) begin
          ld = 1'b1;
          nxt = evc_q[e][`EVC_NXT_LO+2:`EVC_NXT_LO];
        end
      end
    end
    // match 0 as automatic limit
    lim[0] = lim[0] | (cfg_q[`CFG_ALIM_L] & (unify ? m_u[0] : m_l[0]));
    lim[1] = lim[1] | (cfg_q[`CFG_ALIM_H] & m_h[0] & ~unify);
  end
  // counter steps for full width and each half
  wire [32:0] nu = step(cnt_q, dir_q[0], lim[0], cfg_q[`CFG_BIDIR_L], cnt_q == 32'h0);
  wire [32:0] nl = step({16'h0, cnt_q[15:0]}, dir_q[0], lim[0], cfg_q[`CFG_BIDIR_L],
                        cnt_q[15:0] == 16'h0);
  wire [32:0] nh = step({16'h0, cnt_q[31:16]}, dir_q[1], lim[1], cfg_q[`CFG_BIDIR_H],
                        cnt_q[31:16] == 16'h0);
  // bus handshake: one wait cycle, then answer
  wire req = i_read | i_write;
  // writes land only in the answer cycle, once per request
  wire wr = i_write & ack_q;
  // waitrequest stays low while the bus is idle
  assign o_waitrequest = req & ~ack_q;
  // adc trigger taken from one chosen output; choices 6 and 7 give a quiet low
  // instead of an unknown, since only six outputs exist
  wire [7:0] out_x = {2'b00, out_q};
  assign o_adc_trig = out_x[mode_q[`MODE_ADC_LO+2:`MODE_ADC_LO]];
  assign o_out = out_q;
  // main sequential process: counters, state, outputs, captures, bus writes
  integer i;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= 8'h00;
      ctrl_q <= `CTRL_RST;
      dir_q <= 2'b00;
      cnt_q <= 32'h0;
      state_q <= 3'h0;
      insel_q <= 12'h000;
      out_q <= 6'h00;
      flag_q <= 8'h00;
      mode_q <= 11'h000;
      pend_q <= 8'h00;
      iop_q <= 10'h000;
      ckp_q <= 4'h0;
      o_dma_req <= 2'b00;
      o_event_req <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        mc_q[i] <= 32'h0;
        capc_q[i] <= 8'h00;
        evst_q[i] <= 8'h00;
        evc_q[i] <= 19'h0;
        eva_q[i] <= 12'h000;
      end
    end else begin
      iop_q <= iov;
      ckp_q <= in_s;
      o_dma_req <= dma;
      // event request lines pulse one cycle per firing
      o_event_req <= fire;
      // flags: set wins over a clear in the same cycle
      flag_q <= (flag_q & ~((wr && i_address == `ST_A_FLAG) ? i_writedata[7:0] : 8'h00)) | fire;
      // held matches live until their event fires
      // a fired event consumes its own held match
      pend_q <= (pend_q | (mraw & {evc_q[7][`EVC_HOLD], evc_q[6][`EVC_HOLD],
                 evc_q[5][`EVC_HOLD], evc_q[4][`EVC_HOLD], evc_q[3][`EVC_HOLD],
                 evc_q[2][`EVC_HOLD], evc_q[1][`EVC_HOLD], evc_q[0][`EVC_HOLD]})) & ~fire;
      // state changes only on events or bus writes; wraps leave it alone
      if (wr && i_address == `ST_A_STATE)
        state_q <= i_writedata[2:0];
      else if (ld)
        state_q <= nxt;
      // output toggles
      if (wr && i_address == `ST_A_OUT)
        out_q <= i_writedata[5:0];
      else
        out_q <= out_q ^ tog;
      // stop, start and halt per half
      // halt clears only by a bus write; a start event clears stop
      if (wr && i_address == `ST_A_CTRL) begin
        ctrl_q <= i_writedata[3:0];
      end else begin
        ctrl_q[`CTRL_STOP_L] <= (ctrl_q[`CTRL_STOP_L] & ~stt[0]) | stp[0];
        ctrl_q[`CTRL_HALT_L] <= ctrl_q[`CTRL_HALT_L] | hlt_e[0];
        ctrl_q[`CTRL_STOP_H] <= (ctrl_q[`CTRL_STOP_H] & ~stt[1]) | stp[1];
        ctrl_q[`CTRL_HALT_H] <= ctrl_q[`CTRL_HALT_H] | hlt_e[1];
      end
      // counting
      if (wr && i_address == `ST_A_COUNT) begin
        cnt_q <= i_writedata;
      end else if (unify) begin
        if (tick && run[0]) begin
          cnt_q <= nu[31:0];
          dir_q[0] <= nu[32];
        end
      end else begin
        // split mode: no carry passes between the halves
        if (tick && run[0]) begin
          cnt_q[15:0] <= nl[15:0];
          dir_q[0] <= nl[32];
        end
        if (tick && run[1]) begin
          cnt_q[31:16] <= nh[15:0];
          dir_q[1] <= nh[32];
        end
      end
      // configuration writes
      if (wr && i_address == `ST_A_CFG)
        cfg_q <= i_writedata[7:0];
      if (wr && i_address == `ST_A_INSEL)
        insel_q <= i_writedata[11:0];
      if (wr && i_address == `ST_A_MODE)
        mode_q <= i_writedata[10:0];
      // register arrays and captures
      for (i = 0; i < 8; i = i + 1) begin
        // a bus write wins over a capture in the same cycle
        if (wr && hit8(i_address, `ST_B_MATCH) && asel == i[2:0])
          mc_q[i] <= i_writedata;
        else if (mode_q[i] && |(fire & capc_q[i]))
          mc_q[i] <= cnt_q;
        if (wr && hit8(i_address, `ST_B_CAPC) && asel == i[2:0])
          capc_q[i] <= i_writedata[7:0];
        if (wr && hit8(i_address, `ST_B_EVST) && asel == i[2:0])
          evst_q[i] <= i_writedata[7:0];
        if (wr && hit8(i_address, `ST_B_EVC) && asel == i[2:0])
          evc_q[i] <= i_writedata[18:0];
        if (wr && hit8(i_address, `ST_B_EVA) && asel == i[2:0])
          eva_q[i] <= i_writedata[11:0];
      end
    end
  end
  // bus answer and read data
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= 1'b0;
      o_readdata <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_read && !ack_q) begin
        // unmapped addresses and unused upper bits read as zero
        o_readdata <= 32'h0;
        case (i_address)
          `ST_A_CFG: o_readdata <= {24'h0, cfg_q};
          `ST_A_CTRL: o_readdata <= {26'h0, dir_q, ctrl_q};
          `ST_A_COUNT: o_readdata <= cnt_q;
          `ST_A_STATE: o_readdata <= {29'h0, state_q};
          `ST_A_INSEL: o_readdata <= {20'h0, insel_q};
          `ST_A_OUT: o_readdata <= {26'h0, out_q};
          `ST_A_FLAG: o_readdata <= {24'h0, flag_q};
          `ST_A_MODE: o_readdata <= {21'h0, mode_q};
          default: begin
            if (hit8(i_address, `ST_B_MATCH))
              o_readdata <= mc_q[i_address[4:2]];
            else if (hit8(i_address, `ST_B_CAPC))
              o_readdata <= {24'h0, capc_q[i_address[4:2]]};
            else if (hit8(i_address, `ST_B_EVST))
              o_readdata <= {24'h0, evst_q[i_address[4:2]]};
            else if (hit8(i_address, `ST_B_EVC))
              o_readdata <= {13'h0, evc_q[i_address[4:2]]};
            else if (hit8(i_address, `ST_B_EVA))
              o_readdata <= {20'h0, eva_q[i_address[4:2]]};
          end
        endcase
      end
    end
  end
endmodule
